// ==== shared/lpwc_consts.svh ====
// Constants of the low-power wake control block: SFR addresses, field positions,
// reset values, timing counts and the brown-out threshold table.
// Assumes a 50 MHz core clock and an 8-bit SFR bus driven by the CPU core.
//
// Behaviour
// - Brown-out select bits 3..0 pick sixteen rising thresholds, 2.52 V to 4.32 V.
// - Light-sleep wake by interrupt needs its own enable and the global enable.
// - Every enabled interrupt source except brown-out can wake the core from light-sleep.
// - Light-sleep wake enters the interrupt routine at once, then resumes after request.
// - Writing 1 to power control bit 1 enters deep-sleep (stop).
// - Writing 1 to power control bit 0 enters light-sleep (idle).
// - Stop wake by a pin needs only its own enable, not the global enable.
// - Pin 0, pin 1 and pin-group enables arm stop wake of wake pins 0, 1 and, with ext_pin_hi_enable, 2 to 9.
// - Each Port1 wake enable bit arms stop wake of the matching Port1 pin.
// - After stop wake the next instruction runs before any interrupt service.
// - Post-stop interrupt needs global enable, plus Port1 change enable for Port1 wake.
// - Pin interrupt after stop only if pin still triggered after warm-up.
// - Port1 change gives its post-wake interrupt without a later pin sample.
// - Stop is refused while any enabled wake pin is held low.
// - Wake pins 2 to 9 trigger on falling edge; Port1 on any change.
// - Brown-out interrupt needs its own enable and the pin-group enable.
`ifndef LPWC_CONSTS_SVH
`define LPWC_CONSTS_SVH

`define LPWC_PWR_CTRL_ADDR 8'h87
`define LPWC_BO_SEL_ADDR 8'hBF
`define LPWC_LIGHT_SLEEP_BIT 0
`define LPWC_DEEP_SLEEP_BIT 1
`define LPWC_FLAG0_BIT 2
`define LPWC_FLAG1_BIT 3
`define LPWC_BAUD_DBL_BIT 7
`define LPWC_BO_IE_BIT 7
`define LPWC_BO_OUT_BIT 6
`define LPWC_BO_SEL_MSB 3
`define LPWC_BO_SEL_LSB 0
`define LPWC_PWR_CTRL_RESET 8'h00
`define LPWC_BO_SEL_RESET 8'h00
`define LPWC_BO_MV_RESET 13'h09D8
`define LPWC_CLK_PERIOD_NS 20
`define LPWC_WARMUP_NS 1280
`define LPWC_WARMUP_CYC \
  ((`LPWC_WARMUP_NS + `LPWC_CLK_PERIOD_NS - 1) / `LPWC_CLK_PERIOD_NS)
// Thresholds in millivolts, entry 15 first
`define LPWC_LVD_MV_TABLE {13'h10E0, 13'h1068, 13'h0FF0, 13'h0F78, \
  13'h0F00, 13'h0E88, 13'h0E10, 13'h0D98, 13'h0D16, 13'h0C9E, 13'h0C1C, \
  13'h0BAE, 13'h0B2C, 13'h0AB4, 13'h0A3C, 13'h09D8}

`endif

// ==== shared/lpwc_pkg.sv ====
// Types of the low-power wake control block.
// Assumes lpwc_consts.svh provides the numeric constants.
package lpwc_pkg;
  typedef enum logic [4:0] {
    LPWC_RUN    = 5'h01,
    LPWC_IDLE   = 5'h02,
    LPWC_STOP   = 5'h04,
    LPWC_WARM   = 5'h08,
    LPWC_RESUME = 5'h10
  } lpwc_state_e;
  typedef logic [12:0] lpwc_mv_t;
endpackage : lpwc_pkg

// ==== core/lpwc_pin_watch.sv ====
// Per-pin falling-edge watch for wake pins and change watch for Port1 pins.
// Assumes pins are already synchronous to core_clk.
`timescale 1ns/10ps
module lpwc_pin_watch (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Pins
  input wire logic [9:0] wake_pin,
  input wire logic [7:0] port1_pin,
  // Events
  output logic [9:0] pin_fall,
  output logic [7:0] p1_change
);
  logic [9:0] wake_prev;
  logic [7:0] p1_prev;

  genvar i;
  generate
    for (i = 0; i < 10; i++) begin : g_wake
      // Pins idle high, so a reset value of 1 avoids a false edge
      always_ff @(posedge core_clk) begin
        if (!rstn) wake_prev[i] <= 1'b1;
        else if (ce) wake_prev[i] <= wake_pin[i];
      end
      assign pin_fall[i] = wake_prev[i] & ~wake_pin[i];
    end
    for (i = 0; i < 8; i++) begin : g_p1
      always_ff @(posedge core_clk) begin
        if (!rstn) p1_prev[i] <= 1'b1;
        else if (ce) p1_prev[i] <= port1_pin[i];
      end
      assign p1_change[i] = p1_prev[i] ^ port1_pin[i];
    end
  endgenerate
endmodule : lpwc_pin_watch

// ==== core/lpwc_wake_ctrl.sv ====
// Power-mode and wake control: power control and brown-out select SFRs,
// idle/stop entry, wake detection, warm-up and post-wake interrupt request.
// Assumes the CPU core halts while cpu_hold is high and takes wake_irq_req
// as a request to enter the pending interrupt routine.
`timescale 1ns/10ps
`include "lpwc_consts.svh"
module lpwc_wake_ctrl (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // SFR bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Enables held in other SFRs
  input wire logic global_irq_enable,
  input wire logic ext_pin0_enable,
  input wire logic ext_pin1_enable,
  input wire logic [7:0] ext_pin_hi_enable,
  input wire logic pin_group_and_brownout_enable,
  input wire logic [7:0] port1_wake_enable,
  input wire logic port1_change_irq_enable,
  // Other interrupt sources: timers, converter, touch key, SPI, serial ports
  input wire logic [7:0] irq_src_req,
  input wire logic [7:0] irq_src_enable,
  // Pins and brown-out comparator
  input wire logic [9:0] wake_pin,
  input wire logic [7:0] port1_pin,
  input wire logic brownout_detect,
  // Core side
  output logic cpu_hold,
  output logic osc_stop,
  output logic wake_resume,
  output logic wake_irq_req,
  output logic brownout_irq,
  output logic baud_doubler,
  output logic [3:0] brownout_level_sel,
  output lpwc_pkg::lpwc_mv_t brownout_threshold_mv
);
  localparam logic [6:0] WARM_CYC = 7'(`LPWC_WARMUP_CYC);
  localparam logic [207:0] MV_TABLE = `LPWC_LVD_MV_TABLE;

  lpwc_pkg::lpwc_state_e state;
  lpwc_pkg::lpwc_state_e next_state;
  logic light_sleep_request;
  logic deep_sleep_request;
  logic general_flag_0;
  logic general_flag_1;
  logic brownout_irq_enable;
  logic [6:0] warm_cnt;
  logic p1_woke;
  logic irq_hold;
  logic [9:0] pin_fall;
  logic [7:0] p1_change;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire pwr_wr = ce & sfr_wr & (sfr_addr == `LPWC_PWR_CTRL_ADDR);
  wire bo_wr = ce & sfr_wr & (sfr_addr == `LPWC_BO_SEL_ADDR);
  wire [3:0] sel_in = sfr_wdata[`LPWC_BO_SEL_MSB:`LPWC_BO_SEL_LSB];
  wire in_run = (state == lpwc_pkg::LPWC_RUN);
  wire [9:0] wake_en = {ext_pin_hi_enable & {8{pin_group_and_brownout_enable}},
                        ext_pin1_enable, ext_pin0_enable};
  wire [9:0] pin_low = ~wake_pin;
  wire stop_block = |(pin_low & wake_en);
  wire req_stop = pwr_wr & in_run & sfr_wdata[`LPWC_DEEP_SLEEP_BIT] & ~stop_block;
  // A refused stop still lets the idle bit of the same write take effect
  wire req_idle = pwr_wr & in_run & sfr_wdata[`LPWC_LIGHT_SLEEP_BIT] & ~req_stop;
  wire pin_wake = |(pin_fall & wake_en);
  wire p1_wake = |(p1_change & port1_wake_enable);
  wire src_wake = |(irq_src_req & irq_src_enable);
  // Idle wake only by fully enabled interrupts
  wire idle_wake = global_irq_enable & (src_wake | pin_wake
                   | (p1_wake & port1_change_irq_enable));
  wire stop_wake = pin_wake | p1_wake;
  // Pin still triggered after warm-up; a narrow pulse wakes without an interrupt
  wire pin_irq = global_irq_enable & stop_block;
  wire p1_irq = global_irq_enable & port1_change_irq_enable & p1_woke;
  wire warm_done = (warm_cnt == WARM_CYC - 7'h01);
  wire [7:0] pwr_val = {baud_doubler, 3'h0, general_flag_1, general_flag_0,
                        deep_sleep_request, light_sleep_request};
  wire [7:0] bo_val = {brownout_irq_enable, brownout_detect, 2'h0, brownout_level_sel};
  wire [7:0] next_rdata = (sfr_addr == `LPWC_PWR_CTRL_ADDR) ? pwr_val :
                          (sfr_addr == `LPWC_BO_SEL_ADDR) ? bo_val : 8'h00;
  wire [12:0] next_mv = MV_TABLE[13 * sel_in +: 13];

  ////////////////////////////////////////////////////////////////////////////
  // Pin watch

  lpwc_pin_watch u_watch (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .wake_pin(wake_pin),
    .port1_pin(port1_pin),
    .pin_fall(pin_fall),
    .p1_change(p1_change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State machine

  always_comb begin
    next_state = state;
    unique case (state)
      lpwc_pkg::LPWC_RUN: begin
        if (req_stop) next_state = lpwc_pkg::LPWC_STOP;
        else if (req_idle) next_state = lpwc_pkg::LPWC_IDLE;
      end
      lpwc_pkg::LPWC_IDLE: begin
        if (idle_wake) next_state = lpwc_pkg::LPWC_RUN;
      end
      lpwc_pkg::LPWC_STOP: begin
        if (stop_wake) next_state = lpwc_pkg::LPWC_WARM;
      end
      lpwc_pkg::LPWC_WARM: begin
        if (warm_done) next_state = lpwc_pkg::LPWC_RESUME;
      end
      lpwc_pkg::LPWC_RESUME: begin
        next_state = lpwc_pkg::LPWC_RUN;
      end
      default: next_state = lpwc_pkg::LPWC_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) state <= lpwc_pkg::LPWC_RUN;
    else if (ce) state <= next_state;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      warm_cnt <= 7'h00;
      p1_woke <= 1'b0;
    end else if (ce) begin
      warm_cnt <= (state == lpwc_pkg::LPWC_WARM) ? warm_cnt + 7'h01 : 7'h00;
      if (state == lpwc_pkg::LPWC_STOP && stop_wake) p1_woke <= p1_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core handshake

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cpu_hold <= 1'b0;
      osc_stop <= 1'b0;
      wake_resume <= 1'b0;
      wake_irq_req <= 1'b0;
      irq_hold <= 1'b0;
    end else if (ce) begin
      cpu_hold <= ~next_state[0];
      osc_stop <= next_state == lpwc_pkg::LPWC_STOP;
      wake_resume <= state == lpwc_pkg::LPWC_RESUME;
      // Idle wake enters the routine at once
      wake_irq_req <= (state == lpwc_pkg::LPWC_IDLE && idle_wake)
                      | (in_run & irq_hold);
      if (state == lpwc_pkg::LPWC_WARM && warm_done) irq_hold <= pin_irq | p1_irq;
      else if (in_run) irq_hold <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {baud_doubler, general_flag_1, general_flag_0} <= 3'h0;
      light_sleep_request <= 1'b0;
      deep_sleep_request <= 1'b0;
    end else if (ce) begin
      if (pwr_wr) begin
        baud_doubler <= sfr_wdata[`LPWC_BAUD_DBL_BIT];
        general_flag_1 <= sfr_wdata[`LPWC_FLAG1_BIT];
        general_flag_0 <= sfr_wdata[`LPWC_FLAG0_BIT];
      end
      // Request bits fall back on wake so the core proceeds normally
      deep_sleep_request <= req_stop | (deep_sleep_request & ~next_state[0]);
      light_sleep_request <= req_idle | (light_sleep_request & ~next_state[0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      brownout_irq_enable <= 1'b0;
      brownout_level_sel <= 4'h0;
      brownout_threshold_mv <= `LPWC_BO_MV_RESET;
      brownout_irq <= 1'b0;
      sfr_rdata <= 8'h00;
    end else if (ce) begin
      if (bo_wr) begin
        brownout_irq_enable <= sfr_wdata[`LPWC_BO_IE_BIT];
        brownout_level_sel <= sel_in;
        brownout_threshold_mv <= next_mv;
      end
      brownout_irq <= brownout_detect & brownout_irq_enable
                      & pin_group_and_brownout_enable;
      if (sfr_rd) sfr_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn || !ce);

  sequence s_stop_wake; state == lpwc_pkg::LPWC_STOP && stop_wake; endsequence
  sequence s_warm_end; state == lpwc_pkg::LPWC_WARM && warm_done; endsequence

  a_stop_entry: assert property (req_stop |=> osc_stop && deep_sleep_request)
    else $error("stop request not taken");
  a_stop_refused: assert property (pwr_wr && in_run && stop_block |=> !osc_stop)
    else $error("stop entered with pin low");
  a_idle_entry: assert property (req_idle |=> cpu_hold && !osc_stop)
    else $error("idle request not taken");
  a_idle_gate: assert property (
    state == lpwc_pkg::LPWC_IDLE && !global_irq_enable |=> state == lpwc_pkg::LPWC_IDLE)
    else $error("idle woke without global enable");
  a_idle_isr: assert property (
    state == lpwc_pkg::LPWC_IDLE && idle_wake
    |=> wake_irq_req && !cpu_hold && !light_sleep_request)
    else $error("idle wake missed routine entry");
  a_stop_wake: assert property (s_stop_wake |=> state == lpwc_pkg::LPWC_WARM)
    else $error("stop wake ignored");
  // Resume pulse lands two edges after the last warm cycle, the request one later
  a_resume_first: assert property (
    s_warm_end |-> ##2 (wake_resume && !wake_irq_req) ##1 !wake_resume)
    else $error("resume not before routine");
  a_no_irq_global: assert property (
    (s_warm_end and !global_irq_enable) |-> ##3 !wake_irq_req)
    else $error("routine entered with global enable off");
  a_irq_after_resume: assert property (
    (s_warm_end and pin_irq) |-> ##3 wake_irq_req)
    else $error("post-wake interrupt missing");
  a_bod_irq: assert property (brownout_irq |-> $past(pin_group_and_brownout_enable))
    else $error("brownout interrupt without group enable");
  a_stop_bit_clear: assert property (s_warm_end |=> ##1 !deep_sleep_request)
    else $error("stop request bit not cleared");
endmodule : lpwc_wake_ctrl

// ==== sim/lpwc_far_model.sv ====
// Far-side model: wake pins and Port1 pins as the outside world drives them.
// Assumes the bench calls pulse(); pins idle high, as pull-ups would hold them.
`timescale 1ns/10ps
module lpwc_far_model (
  // Clock
  input wire logic core_clk,
  // Pins
  output logic [9:0] wake_pin,
  output logic [7:0] port1_pin
);
  initial begin
    wake_pin = 10'h3FF;
    port1_pin = 8'hFF;
  end
  // A short width gives a wake that the clock never sees after warm-up
  task automatic pulse(input int idx, input int width);
    @(posedge core_clk);
    #1;
    if (idx < 10) wake_pin[idx] = 1'b0;
    else port1_pin[0] = ~port1_pin[0];
    repeat (width) @(posedge core_clk);
    #1;
    wake_pin = 10'h3FF;
  endtask : pulse
endmodule : lpwc_far_model

// ==== sim/testbench.sv ====
// Self-checking bench of the wake controller with an integer reference model.
// Assumes lpwc_pkg is compiled first; ce drops once to show that it freezes state.
`timescale 1ns/10ps
module testbench;
  logic core_clk, rstn, ce, sfr_wr, sfr_rd, brownout_detect, global_irq_enable;
  logic ext_pin0_enable, ext_pin1_enable, pin_group_and_brownout_enable, port1_change_irq_enable;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ext_pin_hi_enable, port1_wake_enable;
  logic [7:0] irq_src_req, irq_src_enable, port1_pin;
  logic [9:0] wake_pin;
  logic cpu_hold, osc_stop, wake_resume, wake_irq_req, brownout_irq, baud_doubler;
  logic [3:0] brownout_level_sel;
  lpwc_pkg::lpwc_mv_t brownout_threshold_mv;
  int bad_count, checked, cycles, tr, ti, exp_irq;
  int mv[16] = '{2520, 2620, 2740, 2860, 2990, 3100, 3230, 3350,
    3480, 3600, 3720, 3840, 3960, 4080, 4200, 4320};
  // Stop cases: pin index (10 = Port1), enable, global, Port1 irq enable, width
  int t_idx[6] = '{0, 1, 2, 10, 10, 0};
  int t_en[6] = '{1, 1, 1, 1, 1, 0};
  int t_g[6] = '{0, 1, 1, 1, 1, 1};
  int t_p1[6] = '{1, 1, 1, 1, 0, 1};
  int t_w[6] = '{80, 80, 2, 1, 1, 80};
  lpwc_wake_ctrl lpwc_wake_ctrl_inst (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .global_irq_enable(global_irq_enable),
    .ext_pin0_enable(ext_pin0_enable), .ext_pin1_enable(ext_pin1_enable),
    .ext_pin_hi_enable(ext_pin_hi_enable),
    .pin_group_and_brownout_enable(pin_group_and_brownout_enable),
    .port1_wake_enable(port1_wake_enable), .port1_change_irq_enable(port1_change_irq_enable),
    .irq_src_req(irq_src_req), .irq_src_enable(irq_src_enable), .wake_pin(wake_pin),
    .port1_pin(port1_pin), .brownout_detect(brownout_detect), .cpu_hold(cpu_hold),
    .osc_stop(osc_stop), .wake_resume(wake_resume), .wake_irq_req(wake_irq_req),
    .brownout_irq(brownout_irq), .baud_doubler(baud_doubler),
    .brownout_level_sel(brownout_level_sel), .brownout_threshold_mv(brownout_threshold_mv));
  lpwc_far_model lpwc_far_model_inst (.core_clk(core_clk), .wake_pin(wake_pin),
    .port1_pin(port1_pin));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 10000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_dut(input int n);
    @(posedge core_clk);
    #1;
    rstn = 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
    rstn = 1'b1;
  endtask : reset_dut
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge core_clk);
    #1;
    sfr_rd = 1'b0;
    chk(what, 16'(exp), 16'(sfr_rdata));
  endtask : rdchk
  // First cycle of a resume pulse and of an irq pulse, -1 if none
  task automatic watch(input int n);
    tr = -1;
    ti = -1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      #1;
      if (wake_resume === 1'b1 && tr < 0) tr = i;
      if (wake_irq_req === 1'b1 && ti < 0) ti = i;
    end
  endtask : watch
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, sfr_wr, sfr_rd, brownout_detect, global_irq_enable, ext_pin0_enable} = 6'h00;
    ce = 1'b1;
    {ext_pin1_enable, pin_group_and_brownout_enable, port1_change_irq_enable} = 3'h0;
    {sfr_addr, sfr_wdata, ext_pin_hi_enable, port1_wake_enable} = 32'h0;
    {irq_src_req, irq_src_enable, cycles, bad_count, checked} = 0;
    void'($urandom(12810));
    reset_dut(4);
    rdchk("pwr_reset", 8'h87, 8'h00);
    chk("thr_reset", 16'h09D8, 16'(brownout_threshold_mv));
    wr(8'h87, 8'hFC);
    rdchk("pwr_flags", 8'h87, 8'h8C);
    chk("baud", 16'h1, 16'(baud_doubler));
    rdchk("unmapped", 8'h88, 8'h00);
    wr(8'h87, 8'h00);
    ce = 1'b0;
    wr(8'h87, 8'h8C);
    ce = 1'b1;
    rdchk("ce_freeze", 8'h87, 8'h00);
    for (int c = 0; c < 16; c++) begin
      pin_group_and_brownout_enable = c[1];
      brownout_detect = 1'($urandom_range(1, 0));
      wr(8'hBF, {c[0], 3'h0, c[3:0]});
      rdchk("bo_sel", 8'hBF, {c[0], brownout_detect, 2'h0, c[3:0]});
      chk("thr", 16'(mv[c]), 16'(brownout_threshold_mv));
      chk("sel", 16'(c), 16'(brownout_level_sel));
      chk("bo_irq", 16'(c[0] & c[1] & brownout_detect), 16'(brownout_irq));
    end
    wr(8'hBF, 8'h00);
    for (int k = 0; k < 2; k++) begin
      irq_src_enable = 8'h01 << $urandom_range(7, 0);
      global_irq_enable = 1'b1;
      wr(8'h87, 8'h01);
      irq_src_req = ~irq_src_enable;
      watch(6);
      chk("idle_hold", 16'h1, 16'(cpu_hold));
      chk("idle_noen", 16'hFFFF, 16'(ti));
      global_irq_enable = 1'b0;
      irq_src_req = irq_src_enable;
      watch(6);
      chk("idle_nowake", 16'hFFFF, 16'(ti));
      global_irq_enable = 1'b1;
      watch(4);
      chk("idle_irq", 16'h1, 16'(ti >= 0 && ti < 2));
      chk("idle_run", 16'h0, 16'(cpu_hold));
      irq_src_req = 8'h00;
      rdchk("idle_clr", 8'h87, 8'h00);
    end
    ext_pin0_enable = 1'b1;
    fork
      lpwc_far_model_inst.pulse(0, 8);
      wr(8'h87, 8'h02);
    join
    rdchk("stop_refuse", 8'h87, 8'h00);
    chk("stop_refuse_osc", 16'h0, 16'(osc_stop));
    for (int j = 0; j < 6; j++) begin
      global_irq_enable = 1'(t_g[j]);
      port1_change_irq_enable = 1'(t_p1[j]);
      ext_pin0_enable = t_idx[j] == 0 && t_en[j] == 1;
      ext_pin1_enable = t_idx[j] == 1 && t_en[j] == 1;
      pin_group_and_brownout_enable = t_idx[j] == 2 && t_en[j] == 1;
      ext_pin_hi_enable = 8'($urandom) & 8'hFE | 8'(pin_group_and_brownout_enable);
      port1_wake_enable = 8'($urandom) & 8'hFE | 8'(t_idx[j] == 10 && t_en[j] == 1);
      wr(8'h87, 8'h02);
      chk("stop_osc", 16'h1, 16'(osc_stop));
      fork
        lpwc_far_model_inst.pulse(t_idx[j], t_w[j]);
        watch(120);
      join
      chk("stop_wake", 16'(t_en[j]), 16'(tr >= 0));
      exp_irq = t_en[j] && t_g[j] && (t_idx[j] == 10 ? t_p1[j] : t_w[j] > 70);
      chk("stop_irq", 16'(exp_irq), 16'(ti > tr));
      if (t_en[j] == 1) rdchk("stop_clr", 8'h87, 8'h00);
      else reset_dut(1);
    end
    chk("reset_outs", 16'h0, 16'({cpu_hold, osc_stop, wake_resume, wake_irq_req}));
    rdchk("reset_pwr", 8'h87, 8'h00);
    end_of_test();
  end
endmodule : testbench
